// *** core/sped_core.sv ***
// Port error-detect status register with recovery handshake and Avalon-MM slave
//
// Overview of operation
// [R1] Set detect bit 26 when a link response carries a tag not outstanding.
// [R2] Capture registers are not loaded for the link response tag mismatch.
// [R3] On recovery, send a link-request symbol to the peer port.
// [R4] Peer answers with the tag it expects on its next new packet.
// [R5] Mismatch when the returned tag was already sent and accepted here.
// [R6] After a mismatch no packet moves until the tags are realigned.
// [R7] Set detect bit 27 on any control symbol unexpected in the link state.
// [R8] Set detect bit 29 on unaligned start or delimiter, or undefined code-group.
// [R9] Capture registers are not loaded for delineation or timeout errors.
// [R10] Set detect bit 30 on an unexpected acknowledge control symbol.
// [R11] Set detect bit 31 when acknowledge or link response misses the timeout.
// [R12] Nonzero write to detect register counts when a set bit is rate enabled.
// [R13] Detect bits reset to zero, bit 28 reads zero, write zero clears.
// [R14] Detect bits are sticky until software clears them.
`timescale 1ns/1ps
`default_nettype none
module sped_core
  import sped_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Avalon-MM slave
  input  wire logic [4:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic [31:0]           avs_readdata,
  output logic                  avs_waitrequest,
  // Transmit sequence state
  input  wire logic [TAG_W-1:0] tx_base_tag,
  input  wire logic [TAG_W-1:0] tx_next_tag,
  input  wire logic             ack_pending,
  // Received symbols
  input  wire logic             rx_ack_valid,
  input  wire logic [TAG_W-1:0] rx_ack_tag,
  input  wire logic             rx_lrsp_valid,
  input  wire logic [TAG_W-1:0] rx_lrsp_tag,
  input  wire logic             rx_ctrl_valid,
  input  wire logic             rx_ctrl_expected,
  // Received code-groups
  input  wire logic             rx_cg_valid,
  input  wire logic             rx_cg_delim,
  input  wire logic             rx_cg_aligned,
  input  wire logic             rx_cg_undefined,
  // Recovery
  input  wire logic             recovery_start,
  input  wire logic             tags_realigned,
  output logic                  tx_link_req,
  output logic                  pkt_xfer_halt,
  // Capture and interrupt
  output logic                  capture_load,
  output logic                  irq
);
  logic [31:0]       rdata_q;
  logic              ack_q;
  logic              acc;
  logic              wr_acc;
  logic [31:0]       wmask;
  logic [31:0]       detect;
  logic [NUM_EV-1:0] ev;
  logic [NUM_EV-1:0] det_q;
  logic [NUM_EV-1:0] irq_stat_q;
  logic [NUM_EV-1:0] irq_en_q;
  logic [31:0]       rate_en_q;
  logic [CNT_W-1:0]  rate_cnt_q;
  logic [TMO_W-1:0]  timeout_q;
  logic              sw_realign;
  logic              tmo_expire;
  logic              lrsp_bad;
  logic              ack_bad;
  logic              tx_link_req_q;
  logic              capture_q;
  sped_rec_t         state_q;

  // Tag lies in the outstanding window; incl adds the next new tag
  function automatic logic tag_in(input logic [TAG_W-1:0] t,
                                  input logic [TAG_W-1:0] b,
                                  input logic [TAG_W-1:0] n,
                                  input logic             incl);
    logic [TAG_W-1:0] d;
    logic [TAG_W-1:0] w;
    d = TAG_W'(t - b);
    w = TAG_W'(n - b);
    return incl ? (d <= w) : (d < w);
  endfunction

  // One wait cycle, then the access completes
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign acc = (avs_read || avs_write) && ack_q;
  assign wr_acc = avs_write && ack_q;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign sw_realign = wr_acc && (avs_address == OFS_LINK_CTL)
                      && wmask[CTL_REALIGN] && avs_writedata[CTL_REALIGN];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  // Event detection
  assign lrsp_bad = !tag_in(rx_lrsp_tag, tx_base_tag, tx_next_tag, 1'b1); // R5
  assign ack_bad = !tag_in(rx_ack_tag, tx_base_tag, tx_next_tag, 1'b0);
  assign ev[EV_MISMATCH] = rx_lrsp_valid && (state_q == SPED_WAIT_RESP) && lrsp_bad; // R1
  assign ev[EV_UNEXP_SYM] = (rx_ctrl_valid && !rx_ctrl_expected)
                            || (rx_lrsp_valid && (state_q != SPED_WAIT_RESP)); // R7
  assign ev[EV_DELIN] = rx_cg_valid && ((rx_cg_delim && !rx_cg_aligned) || rx_cg_undefined); // R8
  assign ev[EV_UNEXP_ACK] = rx_ack_valid && ack_bad; // R10
  assign ev[EV_TIMEOUT] = tmo_expire; // R11

  // Timer runs while an acknowledge or link response is awaited
  sped_timer u_timer (
    .clk     (clk),
    .rst_n   (rst_n),
    .run     (ack_pending || (state_q == SPED_WAIT_RESP)),
    .restart (rx_ack_valid || rx_lrsp_valid || (state_q == SPED_SEND_REQ)),
    .limit   (timeout_q),
    .expire  (tmo_expire)
  );

  // Recovery handshake
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= SPED_IDLE;
    end else begin
      case (state_q)
        SPED_IDLE: begin
          if (recovery_start) begin
            state_q <= SPED_SEND_REQ;
          end
        end
        SPED_SEND_REQ: begin
          state_q <= SPED_WAIT_RESP;
        end
        SPED_WAIT_RESP: begin
          if (rx_lrsp_valid) begin
            state_q <= lrsp_bad ? SPED_HALTED : SPED_IDLE; // R6
          end else if (tmo_expire) begin
            state_q <= SPED_SEND_REQ;
          end
        end
        SPED_HALTED: begin
          if (tags_realigned || sw_realign) begin
            state_q <= SPED_IDLE; // R6
          end
        end
        default: begin
          state_q <= SPED_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_link_req_q <= 1'b0;
    end else begin
      // A timeout in the wait state resends the request as well
      tx_link_req_q <= ((state_q == SPED_IDLE) && recovery_start)
                       || ((state_q == SPED_WAIT_RESP) && !rx_lrsp_valid && tmo_expire); // R3
    end
  end

  assign tx_link_req = tx_link_req_q;
  assign pkt_xfer_halt = (state_q == SPED_HALTED); // R6

  // Capture load only for symbol errors that carry valid capture data
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      capture_q <= 1'b0;
    end else begin
      capture_q <= ev[EV_UNEXP_SYM] || ev[EV_UNEXP_ACK]; // R2 R9
    end
  end

  assign capture_load = capture_q;

  // Sticky detect and interrupt status bits, set wins over clear
  for (genvar i = 0; i < NUM_EV; i++) begin : g_ev
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        det_q[i] <= 1'b0; // R13
      end else if (ev[i]) begin
        det_q[i] <= 1'b1; // R14
      end else if (wr_acc && (avs_address == OFS_DETECT) && wmask[DET_POS[i]]
                   && !avs_writedata[DET_POS[i]]) begin
        det_q[i] <= 1'b0; // R13
      end
    end

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        irq_stat_q[i] <= 1'b0;
      end else if (ev[i]) begin
        irq_stat_q[i] <= 1'b1;
      end else if (wr_acc && (avs_address == OFS_IRQ_CLR) && wmask[i] && avs_writedata[i]) begin
        irq_stat_q[i] <= 1'b0;
      end
    end

    assign detect[DET_POS[i]] = det_q[i];
  end

  assign detect[25:0] = '0;
  assign detect[DET_RSVD_POS] = 1'b0; // R13
  assign irq = |(irq_stat_q & irq_en_q);

  // Writable control registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rate_en_q <= RATE_EN_RST;
    end else if (wr_acc && (avs_address == OFS_RATE_EN)) begin
      rate_en_q <= ((avs_writedata & wmask) | (rate_en_q & ~wmask)) & detect_mask();
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_en_q <= '0;
    end else if (wr_acc && (avs_address == OFS_IRQ_EN) && wmask[0]) begin
      irq_en_q <= avs_writedata[NUM_EV-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timeout_q <= TIMEOUT_RST;
    end else if (wr_acc && (avs_address == OFS_TIMEOUT)) begin
      timeout_q <= (avs_writedata[TMO_W-1:0] & wmask[TMO_W-1:0]) | (timeout_q & ~wmask[TMO_W-1:0]);
    end
  end

  // Error rate counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rate_cnt_q <= '0;
    end else if (wr_acc && (avs_address == OFS_DETECT) && ((avs_writedata & wmask) != '0)
                 && ((avs_writedata & wmask & rate_en_q) != '0)) begin
      rate_cnt_q <= rate_cnt_q + 1'b1; // R12
    end else if (wr_acc && (avs_address == OFS_RATE_CNT)) begin
      rate_cnt_q <= '0;
    end
  end

  // Bits that exist in the detect register
  function automatic logic [31:0] detect_mask();
    logic [31:0] m;
    m = '0;
    for (int k = 0; k < NUM_EV; k++) begin
      m[DET_POS[k]] = 1'b1;
    end
    return m;
  endfunction

  // Read data is latched in the wait cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (avs_read && !ack_q) begin
      if (avs_address == OFS_DETECT) begin
        rdata_q <= detect; // R13
      end else if (avs_address == OFS_RATE_EN) begin
        rdata_q <= rate_en_q;
      end else if (avs_address == OFS_RATE_CNT) begin
        rdata_q <= {{(32-CNT_W){1'b0}}, rate_cnt_q};
      end else if (avs_address == OFS_IRQ_STAT) begin
        rdata_q <= {{(32-NUM_EV){1'b0}}, irq_stat_q};
      end else if (avs_address == OFS_IRQ_EN) begin
        rdata_q <= {{(32-NUM_EV){1'b0}}, irq_en_q};
      end else if (avs_address == OFS_TIMEOUT) begin
        rdata_q <= {{(32-TMO_W){1'b0}}, timeout_q};
      end else if (avs_address == OFS_LINK_CTL) begin
        rdata_q <= {30'h0, pkt_xfer_halt, 1'b0};
      end else begin
        rdata_q <= '0;
      end
    end
  end

  assign avs_readdata = rdata_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_lr_mismatch;
    ev[EV_MISMATCH] |=> det_q[EV_MISMATCH] && pkt_xfer_halt;
  endproperty
  a_lr_mismatch: assert property (p_lr_mismatch) else $error("link response mismatch not flagged"); // R1

  property p_no_capture_lr;
    capture_load |-> $past(ev[EV_UNEXP_SYM] || ev[EV_UNEXP_ACK]);
  endproperty
  a_no_capture_lr: assert property (p_no_capture_lr) else $error("capture load without a symbol error"); // R2

  property p_link_req;
    (state_q == SPED_IDLE && recovery_start) |=> tx_link_req ##1 (state_q == SPED_WAIT_RESP && !tx_link_req);
  endproperty
  a_link_req: assert property (p_link_req) else $error("link request not sent once"); // R3

  property p_good_resp;
    (state_q == SPED_WAIT_RESP && rx_lrsp_valid && !lrsp_bad) |=> !pkt_xfer_halt && !det_q[EV_MISMATCH]
      || $past(det_q[EV_MISMATCH]);
  endproperty
  a_good_resp: assert property (p_good_resp) else $error("good response flagged as mismatch"); // R5

  property p_halt_hold;
    (pkt_xfer_halt && !tags_realigned && !sw_realign) |=> pkt_xfer_halt;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt released before realign"); // R6

  property p_unexp_sym;
    (rx_ctrl_valid && !rx_ctrl_expected) |=> det_q[EV_UNEXP_SYM] && capture_load;
  endproperty
  a_unexp_sym: assert property (p_unexp_sym) else $error("unexpected symbol not flagged"); // R7

  property p_delin;
    (rx_cg_valid && rx_cg_undefined && !ev[EV_UNEXP_SYM] && !ev[EV_UNEXP_ACK]) |=> det_q[EV_DELIN] && !capture_load;
  endproperty
  a_delin: assert property (p_delin) else $error("delineation error mishandled"); // R8

  property p_tmo_nocap;
    (tmo_expire && !ev[EV_UNEXP_SYM] && !ev[EV_UNEXP_ACK]) |=> det_q[EV_TIMEOUT] && !capture_load;
  endproperty
  a_tmo_nocap: assert property (p_tmo_nocap) else $error("timeout mishandled"); // R9

  property p_unexp_ack;
    (rx_ack_valid && tx_base_tag == tx_next_tag) |=> det_q[EV_UNEXP_ACK];
  endproperty
  a_unexp_ack: assert property (p_unexp_ack) else $error("ack with none outstanding not flagged"); // R10

  property p_timeout;
    (state_q == SPED_WAIT_RESP && tmo_expire && !rx_lrsp_valid)
      |=> det_q[EV_TIMEOUT] && state_q == SPED_SEND_REQ && tx_link_req;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not flagged"); // R11

  property p_rate_cnt;
    (wr_acc && avs_address == OFS_DETECT && avs_byteenable == 4'hF && (avs_writedata & rate_en_q) != '0)
      |=> rate_cnt_q == CNT_W'($past(rate_cnt_q) + 1'b1);
  endproperty
  a_rate_cnt: assert property (p_rate_cnt) else $error("rate counter did not step"); // R12

  property p_w0c;
    (wr_acc && avs_address == OFS_DETECT && avs_byteenable[3] && !avs_writedata[DET_POS[EV_TIMEOUT]] && !ev[EV_TIMEOUT])
      |=> !det_q[EV_TIMEOUT];
  endproperty
  a_w0c: assert property (p_w0c) else $error("write zero did not clear"); // R13

  property p_sticky;
    (det_q[EV_DELIN] && !(wr_acc && avs_address == OFS_DETECT)) |=> det_q[EV_DELIN];
  endproperty
  a_sticky: assert property (p_sticky) else $error("detect bit dropped by itself"); // R14

  c_mismatch: cover property (ev[EV_MISMATCH] ##[1:40] sw_realign);
  c_timeout: cover property (state_q == SPED_WAIT_RESP && tmo_expire);
  c_irq: cover property (irq ##1 !irq);
endmodule
`default_nettype wire

// *** core/sped_pkg.sv ***
// Constants and types shared by the port error-detect block
package sped_pkg;
  // Packet sequence tag width, link timeout width, rate counter width and event count
  localparam int TAG_W = 5;
  localparam int TMO_W = 24;
  localparam int CNT_W = 8;
  localparam int NUM_EV = 5;

  // Register byte offsets
  localparam logic [4:0] OFS_DETECT  = 5'h00;
  localparam logic [4:0] OFS_RATE_EN = 5'h04;
  localparam logic [4:0] OFS_RATE_CNT = 5'h08;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h0C;
  localparam logic [4:0] OFS_IRQ_CLR = 5'h10;
  localparam logic [4:0] OFS_IRQ_EN  = 5'h14;
  localparam logic [4:0] OFS_TIMEOUT = 5'h18;
  localparam logic [4:0] OFS_LINK_CTL = 5'h1C;

  // Event index within the interrupt registers
  localparam int EV_MISMATCH = 0;
  localparam int EV_UNEXP_SYM = 1;
  localparam int EV_DELIN = 2;
  localparam int EV_UNEXP_ACK = 3;
  localparam int EV_TIMEOUT = 4;

  // Position of each event in the error detect register
  localparam int DET_POS [NUM_EV] = '{26, 27, 29, 30, 31};
  localparam int DET_RSVD_POS = 28;

  // Link control register fields
  localparam int CTL_REALIGN = 0;
  localparam int CTL_HALTED = 1;

  // Reset values
  localparam logic [31:0] RATE_EN_RST = 32'h0000_0000;
  localparam logic [TMO_W-1:0] TIMEOUT_RST = 24'h00_FFFF;

  // Recovery handshake states
  typedef enum logic [1:0] {
    SPED_IDLE,
    SPED_SEND_REQ,
    SPED_WAIT_RESP,
    SPED_HALTED
  } sped_rec_t;
endpackage

// *** core/sped_timer.sv ***
// Link timeout interval counter
`timescale 1ns/1ps
`default_nettype none
module sped_timer
  import sped_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             run,
  input  wire logic             restart,
  input  wire logic [TMO_W-1:0] limit,
  // Expiry pulse
  output logic                  expire
);
  logic [TMO_W-1:0] count_q;
  logic             expire_q;

  // Counts while waiting; any answer restarts the interval
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (!run || restart || expire_q) begin
      count_q <= '0;
    end else if (count_q != limit) begin
      count_q <= count_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      expire_q <= 1'b0;
    end else begin
      expire_q <= run && !restart && !expire_q && (count_q == limit - 1'b1) && (limit != '0);
    end
  end

  assign expire = expire_q;
endmodule
`default_nettype wire

// *** tb/sped_peer.sv ***
// Peer port model that answers link requests with its expected tag
`timescale 1ns/1ps
`default_nettype none
module sped_peer
  import sped_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Bench control
  input  wire logic [TAG_W-1:0] exp_tag,
  input  wire logic [2:0]       resp_dly,
  input  wire logic             mute,
  // Link symbols
  input  wire logic             tx_link_req,
  output logic                  rx_lrsp_valid,
  output logic [TAG_W-1:0]      rx_lrsp_tag
);
  int cnt_q;

  always_ff @(posedge clk) begin
    rx_lrsp_valid <= 1'h0;
    // Tag line carries no stale value between symbols
    rx_lrsp_tag   <= ~rx_lrsp_tag;
    if (!rst_n) begin
      cnt_q       <= 0;
      rx_lrsp_tag <= '0;
    end else if (tx_link_req && !mute) begin
      cnt_q <= int'(resp_dly) + 1;
    end else if (cnt_q == 1) begin
      cnt_q         <= 0;
      rx_lrsp_valid <= 1'h1;
      rx_lrsp_tag   <= exp_tag;
    end else if (cnt_q > 1) begin
      cnt_q <= cnt_q - 1;
    end
  end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the port error-detect block
`timescale 1ns/1ps
`default_nettype none
module tb
  import sped_pkg::*;
;
  logic             clk = '0, rst_n = '0, rd = '0, wr = '0, wreq, irq, halt, cap, link_req, lrsp_v;
  logic [4:0]       adr = '0;
  logic [31:0]      wd = '0, rdata, q, det_m = '0;
  logic [3:0]       be = 4'hF;
  logic [TAG_W-1:0] base = '0, nxt = '0, ack_tag = '0, exp_tag = '0, lrsp_tag;
  logic             ack_pend = '0, ack_v = '0, ctl_v = '0, ctl_e = '0, mute = '0;
  logic             cg_v = '0, cg_d = '0, cg_a = '0, cg_u = '0, rec = '0, realn = '0;
  logic [2:0]       dly = '0;
  logic [4:0]       ist_m = '0;
  int               error_cnt = 0, n_tests = 0, seed = 54, cyc = 0, req_cnt = 0, cap_cnt = 0;

  always #20 clk = ~clk;

  sped_core sped_core_inst (.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .tx_base_tag(base), .tx_next_tag(nxt), .ack_pending(ack_pend), .rx_ack_valid(ack_v),
    .rx_ack_tag(ack_tag), .rx_lrsp_valid(lrsp_v), .rx_lrsp_tag(lrsp_tag), .rx_ctrl_valid(ctl_v),
    .rx_ctrl_expected(ctl_e), .rx_cg_valid(cg_v), .rx_cg_delim(cg_d), .rx_cg_aligned(cg_a),
    .rx_cg_undefined(cg_u), .recovery_start(rec), .tags_realigned(realn), .tx_link_req(link_req),
    .pkt_xfer_halt(halt), .capture_load(cap), .irq(irq));

  sped_peer sped_peer_inst (.clk(clk), .rst_n(rst_n), .exp_tag(exp_tag), .resp_dly(dly), .mute(mute),
    .tx_link_req(link_req), .rx_lrsp_valid(lrsp_v), .rx_lrsp_tag(lrsp_tag));

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Cycle ceiling, link request and capture pulse counters
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (link_req === 1'h1) req_cnt <= req_cnt + 1;
    if (cap === 1'h1) cap_cnt <= cap_cnt + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One Avalon access, held until waitrequest is seen low
  // Request held until waitrequest is sampled low at a rising edge; the cycle ceiling ends a hang
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
    adr <= a; wd <= d; be <= b; wr <= w; rd <= !w;
    @(posedge clk);
    while (wreq !== 1'h0) begin
      @(posedge clk);
    end
    q = rdata;
    wr <= '0; rd <= '0;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    bus(1'h0, a, '0, 4'hF);
    chk(q, e);
  endtask
  task automatic wrt(input logic [4:0] a, input logic [31:0] d); bus(1'h1, a, d, 4'hF); endtask
  task automatic tick(input int n); repeat (n) @(posedge clk); endtask
  task automatic ev(input int k);
    det_m[DET_POS[k]] = 1'h1;
    ist_m[k] = 1'h1;
  endtask
  task automatic clr_all();
    wrt(OFS_DETECT, '0);
    wrt(OFS_IRQ_CLR, 32'h0000_001F);
    det_m = '0;
    ist_m = '0;
  endtask
  task automatic recover(input logic [TAG_W-1:0] t);
    exp_tag <= t; dly <= 3'($random(seed));
    rec <= 1'h1; tick(1); rec <= '0; tick(20);
  endtask

  initial begin
    int t, c0, r0, n;
    tick(6); rst_n <= 1'h1; tick(1);
    rd_chk(OFS_DETECT, '0);
    rd_chk(OFS_TIMEOUT, {8'h00, TIMEOUT_RST});
    rd_chk(OFS_RATE_EN, RATE_EN_RST);
    bus(1'h1, 5'h02, 32'hFFFF_FFFF, 4'hF); rd_chk(5'h02, '0);
    wrt(OFS_DETECT, 32'hFFFF_FFFF); rd_chk(OFS_DETECT, '0);
    wrt(OFS_IRQ_EN, 32'h0000_001F); wrt(OFS_TIMEOUT, 32'h0000_0010);
    // Expected symbol leaves the flags alone, an unexpected one sets them
    ctl_v <= 1'h1; ctl_e <= 1'h1; tick(1); ctl_v <= '0; tick(2);
    rd_chk(OFS_DETECT, det_m);
    ctl_v <= 1'h1; ctl_e <= '0; tick(1); ctl_v <= '0; ctl_e <= 1'h1; @(negedge clk);
    chk(cap, 1'h1);
    ev(EV_UNEXP_SYM); tick(8);
    rd_chk(OFS_DETECT, det_m);
    chk(irq, 1'h1);
    wrt(OFS_IRQ_STAT, '0); rd_chk(OFS_IRQ_STAT, {27'h0, ist_m});
    wrt(OFS_IRQ_EN, '0); chk(irq, '0);
    wrt(OFS_IRQ_EN, 32'h0000_001F); chk(irq, 1'h1);
    wrt(OFS_IRQ_CLR, 32'h0000_0002); ist_m = '0; chk(irq, '0);
    rd_chk(OFS_DETECT, det_m);
    bus(1'h1, OFS_DETECT, '0, 4'h7); rd_chk(OFS_DETECT, det_m);
    clr_all(); rd_chk(OFS_DETECT, '0);
    // Unaligned delimiter, aligned delimiter, undefined code-group
    for (int i = 0; i < 3; i++) begin
      cg_v <= 1'h1; cg_d <= (i < 2); cg_a <= (i == 1); cg_u <= (i == 2);
      tick(1); cg_v <= '0; @(negedge clk);
      chk(cap, '0);
      if (i != 1) ev(EV_DELIN);
      tick(1); rd_chk(OFS_DETECT, det_m);
      clr_all();
    end
    // Acknowledge while nothing is outstanding
    ack_tag <= 5'($random(seed)); ack_v <= 1'h1; tick(1); ack_v <= '0; tick(1);
    ev(EV_UNEXP_ACK);
    rd_chk(OFS_DETECT, det_m);
    clr_all();
    // Acknowledges against outstanding tags 3..5, upper boundary 5 and 6 first
    base <= 5'h03; nxt <= 5'h06;
    for (int i = 0; i < 8; i++) begin
      t = (i == 0) ? 5 : (i == 1) ? 6 : $random(seed);
      ack_tag <= t[4:0]; ack_v <= 1'h1; tick(1); ack_v <= '0; ack_tag <= ~t[4:0]; tick(1);
      if (((t - 3) & 31) >= 3) ev(EV_UNEXP_ACK);
      rd_chk(OFS_DETECT, det_m);
      clr_all();
    end
    wrt(OFS_RATE_EN, 32'hFFFF_FFFF); rd_chk(OFS_RATE_EN, 32'hEC00_0000);
    wrt(OFS_DETECT, 32'h0000_0001); wrt(OFS_DETECT, 32'h0800_0000); wrt(OFS_DETECT, '0);
    rd_chk(OFS_RATE_CNT, 32'h0000_0001);
    bus(1'h1, OFS_DETECT, 32'h0800_0000, 4'h7); rd_chk(OFS_RATE_CNT, 32'h0000_0001);
    wrt(OFS_RATE_CNT, '0); rd_chk(OFS_RATE_CNT, '0);
    // Good response: next tag is inside the window
    r0 = req_cnt; recover(5'h06);
    chk(req_cnt, r0 + 1);
    chk(halt, '0);
    rd_chk(OFS_DETECT, det_m);
    // Response naming an accepted tag, then realigned two ways
    for (int j = 0; j < 2; j++) begin
      c0 = cap_cnt; recover(5'h01); ev(EV_MISMATCH);
      chk(halt, 1'h1);
      rd_chk(OFS_DETECT, det_m);
      bus(1'h0, OFS_LINK_CTL, '0, 4'hF); chk(q[CTL_HALTED], 1'h1);
      chk(cap_cnt, c0);
      if (j == 0) begin
        realn <= 1'h1; tick(1); realn <= '0; tick(1);
      end else wrt(OFS_LINK_CTL, 32'h0000_0001);
      chk(halt, '0);
      clr_all();
    end
    // Silent peer: timeout flags and resends the request
    c0 = cap_cnt; r0 = req_cnt; n = 0; mute <= 1'h1; recover(5'h05);
    while (req_cnt < r0 + 2 && n < 200) begin
      tick(1);
      n++;
    end
    chk(req_cnt, r0 + 2);
    tick(2); ev(EV_TIMEOUT);
    rd_chk(OFS_DETECT, det_m);
    chk(cap_cnt, c0);
    rd_chk(OFS_IRQ_STAT, {27'h0, ist_m}); chk(irq, 1'h1);
    mute <= '0; tick(60); chk(halt, '0);
    report_and_stop();
  end
endmodule
`default_nettype wire
